// ---- rtl/sbc_bank_fsm.sv ----
/*
  per-bank command state machine with cke power-state handling.
  assumes command decoded by the caller, cke/cs sampled on clk.
*/
// Function
// - cke change judged from previous and current
// - command evaluated against state before edge
// - resetting power down exit goes idle after tinit5
// - bank commands need cke high twice, exit time
// - idle after precharge and trp
// - active after trcd, nothing in progress
// - reading until burst done or terminated
// - writing until burst done or terminated
// - precharge goes precharging then idle after trp
// - activate goes row activating then active
// - read auto close busy until trp
// - write auto close busy until trp
// - read restarts, burst terminate to active
// - write restarts, burst terminate to active
// - mode register write enters mrw state
// - mode register write ends after tmrw
// - all-bank refresh holds until trfcab
`timescale 1ns/100ps
`default_nettype none
`include "sbc_defs.svh"
module sbc_bank_fsm #(
  parameter int TINIT5_CYC = 2000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire sbc_pkg::sbc_cmd_t cmd,
  input wire logic auto_close_after_burst,
  output sbc_pkg::sbc_state_t state,
  output logic bank_busy,
  output logic cmd_ready
);
  import sbc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // cke sampling; cke is synchronous to clk from the controller
  logic cke_prev_q;
  sbc_state_t st_q, st_d;
  logic [7:0] tmr_q, tmr_d;
  logic [7:0] exit_q, exit_d;
  logic [15:0] init_q;
  logic busy_q, ready_q;

  wire cke_hh = cke_prev_q & cke;
  wire cke_fall = cke_prev_q & ~cke;
  wire cke_rise = ~cke_prev_q & cke;
  wire sel = ~cs_n;
  wire exit_done = (exit_q == 8'h00);
  wire cmd_ok = cke_hh & sel & exit_done;
  wire tmr_done = (tmr_q == 8'h00);
  wire init_done = (init_q == 16'h0000);

  ////////////////////////////////////////////////////////////////////////
  // next state, always from the state held before this edge
  always_comb begin
    st_d = st_q;
    tmr_d = (tmr_q != 8'h00) ? tmr_q - 8'h01 : 8'h00;
    exit_d = (exit_q != 8'h00) ? exit_q - 8'h01 : 8'h00;
    case (st_q)
      SBC_ST_POWER_ON: begin
        if (cmd_ok && cmd == SBC_CMD_RESET) begin
          st_d = SBC_ST_RESETTING;
        end
      end
      SBC_ST_RESETTING: begin
        if (cke_fall) begin
          st_d = SBC_ST_RESET_PD;
        end else if (cmd_ok && cmd == SBC_CMD_MRR) begin
          st_d = SBC_ST_RESET_MRR;
          tmr_d = 8'(`SBC_TMRR_CYC - 1);
        end else if (init_done) begin
          st_d = SBC_ST_IDLE;
        end
      end
      SBC_ST_RESET_PD: begin
        if (cke_rise) begin
          // stays resetting until tinit5 has run out
          st_d = init_done ? SBC_ST_IDLE : SBC_ST_RESETTING;
          exit_d = 8'(`SBC_TXP_CYC);
        end
      end
      SBC_ST_RESET_MRR: begin
        if (tmr_done) begin
          st_d = SBC_ST_RESETTING;
        end
      end
      SBC_ST_IDLE: begin
        if (cke_fall && sel && cmd == SBC_CMD_SREF) begin
          st_d = SBC_ST_SREF;
        end else if (cke_fall && sel && cmd == SBC_CMD_DPD) begin
          st_d = SBC_ST_DPD;
        end else if (cke_fall) begin
          st_d = SBC_ST_IDLE_PD;
        end else if (cmd_ok) begin
          case (cmd)
            SBC_CMD_ACT: begin
              st_d = SBC_ST_ROW_ACT;
              tmr_d = 8'(`SBC_TRCD_CYC - 1);
            end
            SBC_CMD_MRW: begin
              st_d = SBC_ST_MRW;
              tmr_d = 8'(`SBC_TMRW_CYC - 1);
            end
            SBC_CMD_MRR: begin
              st_d = SBC_ST_IDLE_MRR;
              tmr_d = 8'(`SBC_TMRR_CYC - 1);
            end
            SBC_CMD_REFAB: begin
              st_d = SBC_ST_REFAB;
              tmr_d = 8'(`SBC_TRFCAB_CYC - 1);
            end
            SBC_CMD_PRE: begin
              // trp applies even from idle
              st_d = SBC_ST_PRECHARGING;
              tmr_d = 8'(`SBC_TRP_CYC - 1);
            end
            SBC_CMD_RESET: begin
              st_d = SBC_ST_RESETTING;
            end
            default: begin
              st_d = st_q;
            end
          endcase
        end
      end
      SBC_ST_IDLE_MRR: begin
        if (tmr_done) begin
          st_d = SBC_ST_IDLE;
        end
      end
      SBC_ST_MRW: begin
        if (tmr_done) begin
          st_d = SBC_ST_IDLE;
        end
      end
      SBC_ST_REFAB: begin
        if (tmr_done) begin
          st_d = SBC_ST_IDLE;
        end
      end
      SBC_ST_SREF: begin
        if (cke_rise) begin
          st_d = SBC_ST_IDLE;
          exit_d = 8'(`SBC_TXSR_CYC);
        end
      end
      SBC_ST_DPD: begin
        // leaving deep power down needs a full reset sequence
        if (cke_rise) begin
          st_d = SBC_ST_POWER_ON;
        end
      end
      SBC_ST_IDLE_PD: begin
        if (cke_rise) begin
          st_d = SBC_ST_IDLE;
          exit_d = 8'(`SBC_TXP_CYC);
        end
      end
      SBC_ST_ACT_PD: begin
        if (cke_rise) begin
          st_d = SBC_ST_ACTIVE;
          exit_d = 8'(`SBC_TXP_CYC);
        end
      end
      SBC_ST_ROW_ACT: begin
        if (tmr_done) begin
          st_d = SBC_ST_ACTIVE;
        end
      end
      SBC_ST_ACTIVE: begin
        if (cke_fall) begin
          st_d = SBC_ST_ACT_PD;
        end else if (cmd_ok) begin
          case (cmd)
            SBC_CMD_RD: begin
              st_d = auto_close_after_burst ? SBC_ST_RD_AUTO : SBC_ST_READING;
              tmr_d = 8'(auto_close_after_burst ?
                `SBC_BURST_CYC + `SBC_TRP_CYC - 1 : `SBC_BURST_CYC - 1);
            end
            SBC_CMD_WR: begin
              st_d = auto_close_after_burst ? SBC_ST_WR_AUTO : SBC_ST_WRITING;
              tmr_d = 8'(auto_close_after_burst ?
                `SBC_BURST_CYC + `SBC_TRP_CYC - 1 : `SBC_BURST_CYC - 1);
            end
            SBC_CMD_MRR: begin
              st_d = SBC_ST_ACT_MRR;
              tmr_d = 8'(`SBC_TMRR_CYC - 1);
            end
            SBC_CMD_PRE: begin
              st_d = SBC_ST_PRECHARGING;
              tmr_d = 8'(`SBC_TRP_CYC - 1);
            end
            default: begin
              st_d = st_q;
            end
          endcase
        end
      end
      SBC_ST_ACT_MRR: begin
        if (tmr_done) begin
          st_d = SBC_ST_ACTIVE;
        end
      end
      SBC_ST_READING, SBC_ST_WRITING: begin
        if (cmd_ok && cmd == SBC_CMD_BST) begin
          st_d = SBC_ST_ACTIVE;
        end else if (cmd_ok && cmd == SBC_CMD_RD) begin
          st_d = auto_close_after_burst ? SBC_ST_RD_AUTO : SBC_ST_READING;
          tmr_d = 8'(auto_close_after_burst ?
            `SBC_BURST_CYC + `SBC_TRP_CYC - 1 : `SBC_BURST_CYC - 1);
        end else if (cmd_ok && cmd == SBC_CMD_WR) begin
          st_d = auto_close_after_burst ? SBC_ST_WR_AUTO : SBC_ST_WRITING;
          tmr_d = 8'(auto_close_after_burst ?
            `SBC_BURST_CYC + `SBC_TRP_CYC - 1 : `SBC_BURST_CYC - 1);
        end else if (cmd_ok && cmd == SBC_CMD_PRE) begin
          st_d = SBC_ST_PRECHARGING;
          tmr_d = 8'(`SBC_TRP_CYC - 1);
        end else if (tmr_done) begin
          st_d = SBC_ST_ACTIVE;
        end
      end
      SBC_ST_RD_AUTO, SBC_ST_WR_AUTO: begin
        // commands to this bank are ignored here
        if (tmr_done) begin
          st_d = SBC_ST_IDLE;
        end
      end
      SBC_ST_PRECHARGING: begin
        if (tmr_done) begin
          st_d = SBC_ST_IDLE;
        end
      end
      default: begin
        st_d = SBC_ST_POWER_ON;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // busy when a timed state other than reading or writing is running: bank takes no command then
  wire busy_d = (st_d == SBC_ST_ROW_ACT) || (st_d == SBC_ST_PRECHARGING) ||
    (st_d == SBC_ST_RD_AUTO) || (st_d == SBC_ST_WR_AUTO) ||
    (st_d == SBC_ST_MRW) || (st_d == SBC_ST_REFAB) ||
    (st_d == SBC_ST_IDLE_MRR) || (st_d == SBC_ST_ACT_MRR) ||
    (st_d == SBC_ST_RESET_MRR);
  wire ready_d = ~busy_d && (exit_d == 8'h00) &&
    ((st_d == SBC_ST_IDLE) || (st_d == SBC_ST_ACTIVE) ||
     (st_d == SBC_ST_READING) || (st_d == SBC_ST_WRITING));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= SBC_ST_POWER_ON;
      tmr_q <= 8'h00;
      exit_q <= 8'h00;
      // cke idles high, so reset leaves no false edge behind
      cke_prev_q <= 1'b1;
      busy_q <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      exit_q <= exit_d;
      cke_prev_q <= cke;
      busy_q <= busy_d;
      ready_q <= ready_d;
    end
  end

  // tinit5 runs from entry into resetting
  // a reset command from idle restarts it as well
  wire init_load = (st_q == SBC_ST_POWER_ON) ||
    ((st_q == SBC_ST_IDLE) && (st_d == SBC_ST_RESETTING));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      init_q <= 16'h0000;
    end else if (init_load) begin
      init_q <= 16'(TINIT5_CYC);
    end else if (!init_done) begin
      init_q <= init_q - 16'h0001;
    end
  end

  assign state = st_q;
  assign bank_busy = busy_q;
  assign cmd_ready = ready_q;
endmodule : sbc_bank_fsm
`default_nettype wire

// ---- rtl/sbc_defs.svh ----
/*
  timing counts for the sdram bank command fsm.
  assumes a 200 mhz interface clock; times are in ps.
*/
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH
`define SBC_CLK_PS 5000
`define SBC_TRP_PS 18000
`define SBC_TRCD_PS 18000
`define SBC_TMRW_PS 25000
`define SBC_TRFCAB_PS 130000
`define SBC_TXP_PS 7500
`define SBC_TXSR_PS 140000
`define SBC_TMRR_PS 10000
`define SBC_CYC(ps) (((ps) + `SBC_CLK_PS - 1) / `SBC_CLK_PS)
`define SBC_TRP_CYC `SBC_CYC(`SBC_TRP_PS)
`define SBC_TRCD_CYC `SBC_CYC(`SBC_TRCD_PS)
`define SBC_TMRW_CYC `SBC_CYC(`SBC_TMRW_PS)
`define SBC_TRFCAB_CYC `SBC_CYC(`SBC_TRFCAB_PS)
`define SBC_TXP_CYC `SBC_CYC(`SBC_TXP_PS)
`define SBC_TXSR_CYC `SBC_CYC(`SBC_TXSR_PS)
`define SBC_TMRR_CYC `SBC_CYC(`SBC_TMRR_PS)
`define SBC_BURST_CYC 4
`endif

// ---- rtl/sbc_pkg.sv ----
/*
  types for the sdram bank command fsm.
  assumes nothing beyond a systemverilog compiler.
*/
package sbc_pkg;
  typedef enum logic [3:0] {
    SBC_CMD_NOP, SBC_CMD_ACT, SBC_CMD_RD, SBC_CMD_WR, SBC_CMD_PRE,
    SBC_CMD_BST, SBC_CMD_MRW, SBC_CMD_MRR, SBC_CMD_REFAB, SBC_CMD_RESET,
    SBC_CMD_SREF, SBC_CMD_DPD
  } sbc_cmd_t;
  typedef enum logic [4:0] {
    SBC_ST_POWER_ON, SBC_ST_RESETTING, SBC_ST_RESET_PD, SBC_ST_RESET_MRR,
    SBC_ST_IDLE, SBC_ST_IDLE_MRR, SBC_ST_MRW, SBC_ST_REFAB, SBC_ST_SREF,
    SBC_ST_DPD, SBC_ST_IDLE_PD, SBC_ST_ACT_PD, SBC_ST_ROW_ACT,
    SBC_ST_ACTIVE, SBC_ST_ACT_MRR, SBC_ST_READING, SBC_ST_WRITING,
    SBC_ST_RD_AUTO, SBC_ST_WR_AUTO, SBC_ST_PRECHARGING
  } sbc_state_t;
endpackage : sbc_pkg

// ---- testbench/sbc_bank_chk.sv ----
/*
  assertions on the ports of the bank command fsm.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module sbc_bank_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire sbc_pkg::sbc_cmd_t cmd,
  input wire logic auto_close_after_burst,
  input wire sbc_pkg::sbc_state_t state,
  input wire logic bank_busy,
  input wire logic cmd_ready
);
  import sbc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // ready gates the take, so exit time is covered without a timer here
  sequence s_take(sbc_state_t st, sbc_cmd_t c);
    state == st && $past(cke) && cke && !cs_n && cmd_ready && cmd == c;
  endsequence
  property p_act;
    s_take(SBC_ST_IDLE, SBC_CMD_ACT) |=>
      state == SBC_ST_ROW_ACT [*4] ##1 state == SBC_ST_ACTIVE;
  endproperty
  a_act: assert property (p_act) else $error("bad activate");
  property p_pre;
    s_take(SBC_ST_ACTIVE, SBC_CMD_PRE) |=>
      state == SBC_ST_PRECHARGING [*4] ##1 state == SBC_ST_IDLE;
  endproperty
  a_pre: assert property (p_pre) else $error("bad precharge");
  property p_rda;
    s_take(SBC_ST_ACTIVE, SBC_CMD_RD) ##0 auto_close_after_burst |=>
      state == SBC_ST_RD_AUTO [*8] ##1 state == SBC_ST_IDLE;
  endproperty
  a_rda: assert property (p_rda) else $error("bad auto read");
  property p_rdr;
    s_take(SBC_ST_READING, SBC_CMD_RD) ##0 !auto_close_after_burst |=>
      state == SBC_ST_READING [*4] ##1 state == SBC_ST_ACTIVE;
  endproperty
  a_rdr: assert property (p_rdr) else $error("bad read restart");
  property p_wbst;
    s_take(SBC_ST_WRITING, SBC_CMD_BST) |=> state == SBC_ST_ACTIVE;
  endproperty
  a_wbst: assert property (p_wbst) else $error("bad terminate");
  property p_mrw;
    s_take(SBC_ST_IDLE, SBC_CMD_MRW) |=>
      state == SBC_ST_MRW [*5] ##1 state == SBC_ST_IDLE;
  endproperty
  a_mrw: assert property (p_mrw) else $error("bad mode write");
  property p_ref;
    s_take(SBC_ST_IDLE, SBC_CMD_REFAB) |=> state == SBC_ST_REFAB ##25
      state == SBC_ST_REFAB ##1 state == SBC_ST_IDLE;
  endproperty
  a_ref: assert property (p_ref) else $error("bad refresh");
  property p_sref;
    state == SBC_ST_IDLE && $past(cke) && !cke && !cs_n &&
      cmd == SBC_CMD_SREF |=> state == SBC_ST_SREF;
  endproperty
  a_sref: assert property (p_sref) else $error("bad sref entry");
  property p_exit;
    state == SBC_ST_IDLE && !cmd_ready && cke && $past(cke) |=>
      state == SBC_ST_IDLE;
  endproperty
  a_exit: assert property (p_exit) else $error("exit time");
  property p_busy;
    (state == SBC_ST_ROW_ACT || state == SBC_ST_PRECHARGING ||
      state == SBC_ST_RD_AUTO || state == SBC_ST_WR_AUTO) |->
      bank_busy && !cmd_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("not busy");
endmodule : sbc_bank_chk
bind sbc_bank_fsm sbc_bank_chk u_chk (
  .clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .cmd(cmd),
  .auto_close_after_burst(auto_close_after_burst), .state(state),
  .bank_busy(bank_busy), .cmd_ready(cmd_ready)
);
`default_nettype wire

// ---- testbench/sbc_ctrl_model.sv ----
/*
  controller model driving the bank pins from bench requests.
  assumes requests change only at the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module sbc_ctrl_model (
  input wire logic bank_busy,
  input wire logic req_cke,
  input wire logic req_ap,
  input wire sbc_pkg::sbc_cmd_t req_cmd,
  output logic cke,
  output logic cs_n,
  output logic auto_close_after_burst,
  output sbc_pkg::sbc_cmd_t cmd
);
  import sbc_pkg::*;
  wire sbc_cmd_t gated_cmd;
  // swallow requests while the bank is busy rather than break them; reading and writing still pass them
  assign gated_cmd = bank_busy ? SBC_CMD_NOP : req_cmd;
  assign cmd = gated_cmd;
  assign cs_n = (gated_cmd == SBC_CMD_NOP);
  assign cke = req_cke;
  assign auto_close_after_burst = req_ap;
endmodule : sbc_ctrl_model
`default_nettype wire

// ---- testbench/sbc_bank_fsm_test.sv ----
/*
  bench for the bank fsm: table of command rows, then a mid-run reset.
  assumes the controller model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
module sbc_bank_fsm_test;
  import sbc_pkg::*;
  typedef struct {
    sbc_cmd_t c; logic a; logic k; int n; sbc_state_t e;
  } sbc_row_t;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic req_cke = 1'h1;
  logic req_ap = 1'h0;
  sbc_cmd_t req_cmd = SBC_CMD_NOP;
  wire logic cke, cs_n, ap, busy, ready;
  wire sbc_cmd_t cmd;
  wire sbc_state_t state;
  int miscompares = 0;
  int n_tests = 0;
  // refused rows break exit times on purpose
  sbc_row_t rows [49] = '{
    '{SBC_CMD_NOP, 1'h0, 1'h1, 0, SBC_ST_POWER_ON},
    '{SBC_CMD_RESET, 1'h0, 1'h1, 0, SBC_ST_RESETTING},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 12, SBC_ST_IDLE},
    '{SBC_CMD_ACT, 1'h0, 1'h1, 4, SBC_ST_ACTIVE},
    '{SBC_CMD_RD, 1'h0, 1'h1, 0, SBC_ST_READING},
    '{SBC_CMD_RD, 1'h0, 1'h1, 2, SBC_ST_READING},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 1, SBC_ST_ACTIVE},
    '{SBC_CMD_WR, 1'h0, 1'h1, 0, SBC_ST_WRITING},
    '{SBC_CMD_WR, 1'h0, 1'h1, 0, SBC_ST_WRITING},
    '{SBC_CMD_BST, 1'h0, 1'h1, 0, SBC_ST_ACTIVE},
    '{SBC_CMD_MRR, 1'h0, 1'h1, 2, SBC_ST_ACTIVE},
    '{SBC_CMD_RD, 1'h1, 1'h1, 8, SBC_ST_IDLE},
    '{SBC_CMD_ACT, 1'h0, 1'h1, 4, SBC_ST_ACTIVE},
    '{SBC_CMD_WR, 1'h1, 1'h1, 8, SBC_ST_IDLE},
    '{SBC_CMD_ACT, 1'h0, 1'h1, 4, SBC_ST_ACTIVE},
    '{SBC_CMD_PRE, 1'h0, 1'h1, 4, SBC_ST_IDLE},
    '{SBC_CMD_REFAB, 1'h0, 1'h1, 26, SBC_ST_IDLE},
    '{SBC_CMD_SREF, 1'h0, 1'h0, 1, SBC_ST_SREF},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 0, SBC_ST_IDLE},
    '{SBC_CMD_ACT, 1'h0, 1'h1, 0, SBC_ST_IDLE},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 28, SBC_ST_IDLE},
    '{SBC_CMD_MRW, 1'h0, 1'h1, 0, SBC_ST_MRW},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 4, SBC_ST_IDLE},
    '{SBC_CMD_NOP, 1'h0, 1'h0, 0, SBC_ST_IDLE_PD},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 0, SBC_ST_IDLE},
    '{SBC_CMD_ACT, 1'h0, 1'h1, 0, SBC_ST_IDLE},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 2, SBC_ST_IDLE},
    '{SBC_CMD_DPD, 1'h0, 1'h0, 1, SBC_ST_DPD},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 0, SBC_ST_POWER_ON},
    '{SBC_CMD_RESET, 1'h0, 1'h1, 0, SBC_ST_RESETTING},
    '{SBC_CMD_NOP, 1'h0, 1'h0, 12, SBC_ST_RESET_PD},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 0, SBC_ST_IDLE},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 2, SBC_ST_IDLE},
    '{SBC_CMD_MRR, 1'h0, 1'h1, 0, SBC_ST_IDLE_MRR},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 1, SBC_ST_IDLE},
    '{SBC_CMD_PRE, 1'h0, 1'h1, 0, SBC_ST_PRECHARGING},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 3, SBC_ST_IDLE},
    '{SBC_CMD_ACT, 1'h0, 1'h1, 4, SBC_ST_ACTIVE},
    '{SBC_CMD_NOP, 1'h0, 1'h0, 0, SBC_ST_ACT_PD},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 2, SBC_ST_ACTIVE},
    '{SBC_CMD_WR, 1'h0, 1'h1, 0, SBC_ST_WRITING},
    '{SBC_CMD_RD, 1'h0, 1'h1, 0, SBC_ST_READING},
    '{SBC_CMD_PRE, 1'h0, 1'h1, 0, SBC_ST_PRECHARGING},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 3, SBC_ST_IDLE},
    '{SBC_CMD_RESET, 1'h0, 1'h1, 0, SBC_ST_RESETTING},
    '{SBC_CMD_MRR, 1'h0, 1'h1, 0, SBC_ST_RESET_MRR},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 1, SBC_ST_RESETTING},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 4, SBC_ST_RESETTING},
    '{SBC_CMD_NOP, 1'h0, 1'h1, 3, SBC_ST_IDLE}
  };
  ////////////////////////////////////////////////////////////////////////////
  always #2.5 clk = ~clk;
  sbc_ctrl_model u_ctrl (
    .bank_busy(busy), .req_cke(req_cke), .req_ap(req_ap),
    .req_cmd(req_cmd), .cke(cke), .cs_n(cs_n),
    .auto_close_after_burst(ap), .cmd(cmd)
  );
  // short init count keeps the run brief
  sbc_bank_fsm #(.TINIT5_CYC(10)) u_dut (
    .clk(clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .cmd(cmd),
    .auto_close_after_burst(ap), .state(state), .bank_busy(busy),
    .cmd_ready(ready)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %0d want %0d", $time, seen, exp);
    end
  endtask : check
  // entered at a falling edge, leaves at one
  task automatic step(input sbc_row_t r);
    req_cmd = r.c;
    req_ap = r.a;
    req_cke = r.k;
    @(negedge clk);
    // no wait: the next row replaces the command in this time step
    if (r.n > 0) begin
      req_cmd = SBC_CMD_NOP;
      req_ap = 1'h0;
      repeat (r.n) @(negedge clk);
    end
  endtask : step
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    for (int i = 0; i < 49; i++) begin
      step(rows[i]);
      check(state, rows[i].e);
      $display("row %0d done", i);
    end
    check({4'h0, ready}, 5'h01);
    step('{SBC_CMD_ACT, 1'h0, 1'h1, 0, SBC_ST_ROW_ACT});
    check(state, SBC_ST_ROW_ACT);
    check({4'h0, busy}, 5'h01);
    check({4'h0, ready}, 5'h00);
    rst_n = 1'h0;
    req_cmd = SBC_CMD_NOP;
    repeat (2) @(negedge clk);
    check(state, SBC_ST_POWER_ON);
    check({4'h0, busy}, 5'h00);
    check({4'h0, ready}, 5'h00);
    rst_n = 1'h1;
    step(rows[0]);
    check(state, SBC_ST_POWER_ON);
    step(rows[1]);
    check(state, SBC_ST_RESETTING);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule : sbc_bank_fsm_test
`default_nettype wire
